// ==== rtl/dkcp_core.v ====
// Host command protocol core of the disk controller: status byte, command
// byte, parameter block, one data buffer, mode bits, DMA and drive stream.
// Assumes a host and a DMA controller on the same clock; drive side is
// reduced to a byte stream, a 5-bit bus and a step output.
`include "dkcp_map.vh"

module dkcp_core #(
    parameter BUF_DEPTH = 256,
    parameter PB_DEPTH = 16,
    parameter XFER_WORDS = 16
) (
    input wire clk,
    input wire arst_n,
    input wire host_sel,
    input wire [7:0] host_wdata,
    input wire host_wr,
    input wire host_rd,
    output reg [7:0] host_rdata,
    output wire irq_n,
    output wire dma_req,
    input wire dma_ack,
    input wire [7:0] dma_wdata,
    output reg [7:0] dma_rdata,
    input wire seek_done_in,
    input wire drive_fault_in,
    output reg [7:0] drive_data,
    output reg drive_data_valid,
    output wire [4:0] drive_bus_out,
    output wire [4:0] drive_bus_oe,
    input wire [4:0] drive_bus_in,
    output wire step_pulse,
    output wire nrz_mode,
    output wire hard_sector
);
    // Controller states
    localparam ST_IDLE = 3'd0;
    localparam ST_EXEC = 3'd1;
    localparam ST_DMA = 3'd2;
    localparam ST_DRIVE = 3'd3;
    localparam ST_END = 3'd4;
    // Drive stream phases
    localparam PH_DATA = 2'd0;
    localparam PH_CODE = 2'd1;
    localparam PH_PAD = 2'd2;

    reg [2:0] state_reg; // Controller state
    reg [7:0] status_byte; // Flags seen by host
    reg [7:0] command_byte; // Last command
    reg [7:0] mode_byte_zero; // Configure byte zero
    reg [7:0] mode_byte_one; // Configure byte one
    reg [7:0] parameter_block [0:PB_DEPTH-1];
    reg [7:0] data_buf [0:BUF_DEPTH-1];
    reg [3:0] pb_ptr_reg; // Parameter block pointer
    reg [7:0] buf_ptr_reg; // Buffer pointer
    reg buf_open_reg; // Data port reaches buffer
    reg [7:0] cnt_reg; // Cycle or byte counter
    reg [1:0] phase_reg; // Drive stream phase
    reg dma_gap_reg; // Cycle steal idle slot
    reg seek_seen_reg; // Seek end caught in command
    reg fault_seen_reg; // Fault caught in command
    reg [7:0] step_cnt_reg; // Step pulse timer
    reg check_start; // Check generator preload
    reg [7:0] step_src; // Byte feeding check
    wire [31:0] code_reg; // Running check value
    integer k;

    // Mode bit views
    wire dma_mode = mode_byte_one[`DKCP_M1_DMA];
    wire ecc_mode = mode_byte_zero[`DKCP_M0_ECC];
    wire bus_port = mode_byte_zero[`DKCP_M0_PORT];
    wire [2:0] code_len = ecc_mode ? `DKCP_ECC_BYTES : `DKCP_CRC_BYTES;

    // Command classes
    function is_disk;
        input [7:0] c;
        begin
            is_disk = (c == `DKCP_CMD_READ) || (c == `DKCP_CMD_WRITE) || (c == `DKCP_CMD_FORMAT);
        end
    endfunction
    function is_buf_dma;
        input [7:0] c;
        begin
            is_buf_dma = (c == `DKCP_CMD_M2B) || (c == `DKCP_CMD_B2M);
        end
    endfunction
    function is_seek;
        input [7:0] c;
        begin
            is_seek = (c == `DKCP_CMD_SEEK) || (c == `DKCP_CMD_RECAL);
        end
    endfunction

    // Pad byte: 4E only for soft sector with pad bit set
    wire [7:0] pad_byte = (!mode_byte_zero[`DKCP_M0_SECTOR_FORMAT_BIT] && mode_byte_zero[`DKCP_M0_PAD]) ?
        `DKCP_PAD_GAP : `DKCP_PAD_ZERO;

    // Interrupt from unmasked sticky flags
    assign irq_n = !((status_byte[`DKCP_ST_DONE] && !mode_byte_one[`DKCP_M1_DONEM]) ||
        (status_byte[`DKCP_ST_SEEK] && !mode_byte_one[`DKCP_M1_SEEKM]) ||
        (status_byte[`DKCP_ST_FAULT] && !mode_byte_one[`DKCP_M1_FAULTM]));

    // DMA request during DMA phase; cycle steal leaves idle slots
    assign dma_req = (state_reg == ST_DMA) &&
        (mode_byte_one[`DKCP_M1_BURST] || !dma_gap_reg);

    // Drive pins change function with port type
    assign drive_bus_out = bus_port ? command_byte[4:0] : 5'h00;
    assign drive_bus_oe = (bus_port && state_reg == ST_EXEC && is_seek(command_byte)) ?
        5'h1F : 5'h00;
    assign step_pulse = !bus_port && (step_cnt_reg != 8'h00);
    assign nrz_mode = mode_byte_zero[`DKCP_M0_CODE];
    assign hard_sector = mode_byte_zero[`DKCP_M0_SECTOR_FORMAT_BIT];

    // Byte folded into the check
    always @* begin
        step_src = data_buf[buf_ptr_reg];
    end

    dkcp_check u_check (
        .clk(clk),
        .arst_n(arst_n),
        .start(check_start),
        .ecc_mode(ecc_mode),
        .poly_select_bit(mode_byte_zero[`DKCP_M0_POLY]),
        .seed_select_bit(mode_byte_zero[`DKCP_M0_SEED]),
        .byte_valid(state_reg == ST_DRIVE && phase_reg == PH_DATA),
        .byte_in(step_src),
        .code_reg(code_reg)
    );

    // Host read data, one cycle after the strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            if (host_sel == `DKCP_SEL_CTRL)
                host_rdata <= status_byte;
            else if (buf_open_reg)
                host_rdata <= data_buf[buf_ptr_reg];
            else
                host_rdata <= parameter_block[pb_ptr_reg];
        end
    end

    // Memory arrays without reset: contents are undefined until written,
    // so a disk command run on a fresh buffer streams unknown data
    always @(posedge clk) begin
        // Host data port writes
        if (host_wr && host_sel == `DKCP_SEL_DATA) begin
            if (buf_open_reg)
                data_buf[buf_ptr_reg] <= host_wdata;
            else if (state_reg != ST_EXEC && state_reg != ST_DRIVE && state_reg != ST_DMA)
                parameter_block[pb_ptr_reg] <= host_wdata;
        end
        // DMA writes into buffer for memory to buffer
        if (state_reg == ST_DMA && dma_ack && command_byte == `DKCP_CMD_M2B)
            data_buf[buf_ptr_reg] <= dma_wdata;
        // Results at completion
        if (state_reg == ST_EXEC && cnt_reg == 8'h00 && !is_buf_dma(command_byte) &&
            !is_disk(command_byte)) begin
            parameter_block[0] <= status_byte;
            parameter_block[1] <= {3'b000, drive_bus_in};
        end
        if (state_reg == ST_DRIVE && phase_reg == PH_PAD) begin
            for (k = 0; k < 4; k = k + 1)
                parameter_block[k] <= code_reg[k*8 +: 8];
        end
    end

    // Main control sequence
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            status_byte <= `DKCP_STATUS_RESET;
            command_byte <= 8'h00;
            mode_byte_zero <= `DKCP_MODE_RESET;
            mode_byte_one <= `DKCP_MODE_RESET;
            pb_ptr_reg <= 4'h0;
            buf_ptr_reg <= 8'h00;
            buf_open_reg <= 1'b0;
            cnt_reg <= 8'h00;
            phase_reg <= PH_DATA;
            dma_gap_reg <= 1'b0;
            seek_seen_reg <= 1'b0;
            fault_seen_reg <= 1'b0;
            step_cnt_reg <= 8'h00;
            check_start <= 1'b0;
            drive_data <= 8'h00;
            drive_data_valid <= 1'b0;
            dma_rdata <= 8'h00;
        end else begin
            check_start <= 1'b0;
            drive_data_valid <= 1'b0;
            if (step_cnt_reg != 8'h00)
                step_cnt_reg <= step_cnt_reg - 8'h01;
            // Drive events caught during a command
            if (seek_done_in && state_reg != ST_IDLE && state_reg != ST_END)
                seek_seen_reg <= 1'b1;
            if (drive_fault_in && state_reg != ST_IDLE && state_reg != ST_END)
                fault_seen_reg <= 1'b1;
            // Data port pointer advances on every access
            if ((host_wr || host_rd) && host_sel == `DKCP_SEL_DATA) begin
                if (buf_open_reg)
                    buf_ptr_reg <= buf_ptr_reg + 8'h01;
                else
                    pb_ptr_reg <= pb_ptr_reg + 4'h1;
            end
            // Command byte write
            if (host_wr && host_sel == `DKCP_SEL_CTRL) begin
                command_byte <= host_wdata;
                if (host_wdata == `DKCP_CMD_RECALL) begin
                    status_byte <= 8'h00;
                    pb_ptr_reg <= 4'h0;
                    buf_open_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end else if (state_reg == ST_IDLE) begin
                    status_byte[`DKCP_ST_BUSY] <= 1'b1;
                    state_reg <= ST_EXEC;
                    cnt_reg <= `DKCP_EXEC_CYCLES;
                    buf_open_reg <= 1'b0;
                    seek_seen_reg <= 1'b0;
                    fault_seen_reg <= 1'b0;
                    if (host_wdata == `DKCP_CMD_CONFIG) begin
                        mode_byte_zero <= parameter_block[0];
                        mode_byte_one <= parameter_block[1];
                    end
                    if (is_seek(host_wdata))
                        step_cnt_reg <= `DKCP_STEP_CYCLES;
                end
            end else begin
                case (state_reg)
                    ST_EXEC: begin
                        // Busy already set; run after it
                        if (cnt_reg != 8'h00) begin
                            cnt_reg <= cnt_reg - 8'h01;
                            // Preload the check one cycle ahead, so that the
                            // first data byte is folded in as well
                            check_start <= (cnt_reg == 8'h01) && is_disk(command_byte);
                        end else if (is_disk(command_byte)) begin
                            state_reg <= ST_DRIVE;
                            phase_reg <= PH_DATA;
                            buf_ptr_reg <= 8'h00;
                            cnt_reg <= 8'hFF;
                        end else if (is_buf_dma(command_byte)) begin
                            state_reg <= ST_DMA;
                            buf_ptr_reg <= parameter_block[1];
                            cnt_reg <= XFER_WORDS[7:0];
                        end else begin
                            if (command_byte == `DKCP_CMD_OPEN_BUFFER_READ_COMMAND || command_byte == `DKCP_CMD_OPEN_BUFFER_WRITE_COMMAND) begin
                                buf_open_reg <= 1'b1;
                                buf_ptr_reg <= parameter_block[1];
                            end
                            state_reg <= ST_END;
                        end
                    end
                    ST_DMA: begin
                        // One word per acknowledge
                        dma_gap_reg <= dma_ack && !dma_gap_reg;
                        if (dma_ack) begin
                            dma_rdata <= data_buf[buf_ptr_reg];
                            buf_ptr_reg <= buf_ptr_reg + 8'h01;
                            cnt_reg <= cnt_reg - 8'h01;
                            if (cnt_reg == 8'h01)
                                state_reg <= ST_END;
                        end
                    end
                    ST_DRIVE: begin
                        drive_data_valid <= 1'b1;
                        case (phase_reg)
                            PH_DATA: begin
                                drive_data <= step_src;
                                buf_ptr_reg <= buf_ptr_reg + 8'h01;
                                cnt_reg <= cnt_reg - 8'h01;
                                if (cnt_reg == 8'h00) begin
                                    phase_reg <= PH_CODE;
                                    cnt_reg <= {5'h00, code_len};
                                end
                            end
                            PH_CODE: begin
                                drive_data <= ecc_mode ? code_reg[{cnt_reg[1:0] - 2'd1, 3'b000} +: 8] :
                                    code_reg[{cnt_reg[0] ^ 1'b1, 3'b000} +: 8];
                                cnt_reg <= cnt_reg - 8'h01;
                                if (cnt_reg == 8'h01)
                                    phase_reg <= PH_PAD;
                            end
                            PH_PAD: begin
                                drive_data <= pad_byte;
                                // Correction step applies only when enabled
                                if (mode_byte_zero[`DKCP_M0_AUTO_CORRECT_BIT] && command_byte == `DKCP_CMD_READ)
                                    buf_ptr_reg <= 8'h00;
                                state_reg <= dma_mode ? ST_DMA : ST_END;
                                cnt_reg <= XFER_WORDS[7:0];
                            end
                            default: phase_reg <= PH_DATA;
                        endcase
                    end
                    ST_END: begin
                        // Completion flags, busy drops
                        if (status_byte[`DKCP_ST_BUSY]) begin
                            status_byte[`DKCP_ST_BUSY] <= 1'b0;
                            status_byte[`DKCP_ST_REJECT] <= 1'b1;
                            status_byte[`DKCP_ST_DONE] <= 1'b1;
                            status_byte[`DKCP_ST_SEEK] <= seek_seen_reg;
                            status_byte[`DKCP_ST_FAULT] <= fault_seen_reg;
                            status_byte[`DKCP_ST_ABN] <= fault_seen_reg;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // dkcp_core

// ==== rtl/dkcp_map.vh ====
// Constants of the disk controller host command block: port selects, status
// bit positions, mode bit positions, command codes and fill patterns.
// Assumes inclusion by the block's design files only.
`ifndef DKCP_MAP_VH
`define DKCP_MAP_VH

// Register select values on the host port
`define DKCP_SEL_CTRL 1'b0
`define DKCP_SEL_DATA 1'b1

// Status byte bit positions
`define DKCP_ST_BUSY 7
`define DKCP_ST_REJECT 6
`define DKCP_ST_DONE 5
`define DKCP_ST_SEEK 4
`define DKCP_ST_FAULT 3
`define DKCP_ST_ABN 2
`define DKCP_ST_POLL 1
`define DKCP_STATUS_RESET 8'h00

// Mode byte zero bit positions
`define DKCP_M0_SECTOR_FORMAT_BIT 7
`define DKCP_M0_CODE 6
`define DKCP_M0_PORT 5
`define DKCP_M0_PAD 4
`define DKCP_M0_ECC 3
`define DKCP_M0_POLY 2
`define DKCP_M0_SEED 1
`define DKCP_M0_AUTO_CORRECT_BIT 0
// Mode byte one bit positions
`define DKCP_M1_DMA 7
`define DKCP_M1_BURST 6
`define DKCP_M1_DONEM 5
`define DKCP_M1_SEEKM 4
`define DKCP_M1_FAULTM 3
`define DKCP_MODE_RESET 8'h00

// Command codes
`define DKCP_CMD_CONFIG 8'hE8
`define DKCP_CMD_RECALL 8'h08
`define DKCP_CMD_SEEK 8'hC0
`define DKCP_CMD_RECAL 8'hC8
`define DKCP_CMD_READ 8'h40
`define DKCP_CMD_WRITE 8'h87
`define DKCP_CMD_FORMAT 8'hA3
`define DKCP_CMD_M2B 8'h90
`define DKCP_CMD_B2M 8'h50
`define DKCP_CMD_OPEN_BUFFER_READ_COMMAND 8'h30
`define DKCP_CMD_OPEN_BUFFER_WRITE_COMMAND 8'h38

// Fill patterns, seeds, polynomials and check code lengths
`define DKCP_PAD_GAP 8'h4E
`define DKCP_PAD_ZERO 8'h00
`define DKCP_SEED_ONES 16'hFFFF
`define DKCP_SEED_ZERO 16'h0000
`define DKCP_POLY_CCITT 16'h1021
`define DKCP_POLY_PLAIN 16'h0001
`define DKCP_ECC_POLY 32'h00A00805
`define DKCP_CRC_BYTES 3'h2
`define DKCP_ECC_BYTES 3'h4

// Execution time of a command without data, in cycles
`define DKCP_EXEC_CYCLES 8'h08
// Step pulse width in cycles
`define DKCP_STEP_CYCLES 8'h04

`endif

// ==== rtl/dkcp_check.v ====
// Check code generator for the drive data stream: CRC-16 with selectable
// polynomial and seed, or a 32-bit error correcting code with zero seed.
// Assumes one byte per cycle while byte_valid is high.
`include "dkcp_map.vh"

module dkcp_check (
    input wire clk,
    input wire arst_n,
    input wire start,
    input wire ecc_mode,
    input wire poly_select_bit,
    input wire seed_select_bit,
    input wire byte_valid,
    input wire [7:0] byte_in,
    output reg [31:0] code_reg
);
    // Next check value after one byte, MSB first
    function [31:0] dkcp_step;
        input [31:0] cur;
        input [7:0] din;
        input ecc;
        input poly_sel;
        integer i;
        reg [31:0] c;
        reg fb;
        begin
            c = cur;
            for (i = 7; i >= 0; i = i - 1) begin
                if (ecc) begin
                    fb = c[31] ^ din[i];
                    c = {c[30:0], 1'b0} ^ (fb ? `DKCP_ECC_POLY : 32'h00000000);
                end else begin
                    fb = c[15] ^ din[i];
                    c[15:0] = {c[14:0], 1'b0} ^
                        (fb ? (poly_sel ? `DKCP_POLY_CCITT : `DKCP_POLY_PLAIN) : 16'h0000);
                    c[31:16] = 16'h0000;
                end
            end
            dkcp_step = c;
        end
    endfunction

    // Preload on start, otherwise fold in each byte
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_reg <= 32'h00000000;
        end else if (start) begin
            // Seed of the error code stays zero
            code_reg <= ecc_mode ? 32'h00000000 :
                {16'h0000, seed_select_bit ? `DKCP_SEED_ONES : `DKCP_SEED_ZERO};
        end else if (byte_valid) begin
            code_reg <= dkcp_step(code_reg, byte_in, ecc_mode, poly_select_bit);
        end
    end
endmodule // dkcp_check

// ==== tb/dkcp_monitor.sv ====
// Checker for the disk controller host command block.
// Assumes it is bound to dkcp_core and sees only its ports.
module dkcp_monitor (
    input wire clk,
    input wire arst_n,
    input wire host_sel,
    input wire [7:0] host_wdata,
    input wire host_wr,
    input wire host_rd,
    input wire [7:0] host_rdata,
    input wire irq_n,
    input wire dma_req,
    input wire dma_ack,
    input wire [4:0] drive_bus_oe,
    input wire step_pulse,
    input wire nrz_mode,
    input wire hard_sector
);
    reg [7:0] b0_reg; // Shadow of parameter byte 0
    reg [7:0] b1_reg; // Shadow of parameter byte 1
    reg [7:0] m0_reg; // Shadow mode byte zero
    reg [7:0] m1_reg; // Shadow mode byte one
    reg [3:0] idx_reg; // Shadow parameter pointer
    reg [4:0] age_reg; // Cycles since configure, saturating
    wire cmd_wr = host_wr && !host_sel;
    // Mode checks wait out the execution time of a configure
    wire settled = age_reg > 5'h0C;
    // Track host parameter bytes and configure commands
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b0_reg <= 8'h00;
            b1_reg <= 8'h00;
            m0_reg <= 8'h00;
            m1_reg <= 8'h00;
            idx_reg <= 4'h0;
            age_reg <= 5'h1F;
        end else begin
            if (cmd_wr && host_wdata == 8'h08) begin
                idx_reg <= 4'h0;
            end else if ((host_wr || host_rd) && host_sel) begin
                idx_reg <= idx_reg + 4'h1;
                if (host_wr && idx_reg == 4'h0) b0_reg <= host_wdata;
                if (host_wr && idx_reg == 4'h1) b1_reg <= host_wdata;
            end
            if (cmd_wr && host_wdata == 8'hE8) begin
                m0_reg <= b0_reg;
                m1_reg <= b1_reg;
                age_reg <= 5'h00;
            end else if (age_reg != 5'h1F) begin
                age_reg <= age_reg + 5'h01;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_recall;
        cmd_wr && host_wdata == 8'h08;
    endsequence
    sequence s_stat_rd;
        host_rd && !host_sel;
    endsequence
    a_recall_clear: assert property (s_recall ##1 !host_wr ##1 s_stat_rd |=> host_rdata == 8'h00)
        else $error("status not clear after recall");
    a_recall_irq: assert property (s_recall |=> irq_n)
        else $error("interrupt still active after recall");
    a_mode_view: assert property (settled |-> hard_sector == m0_reg[7] && nrz_mode == m0_reg[6])
        else $error("mode view differs from configured mode");
    a_irq_masked: assert property (settled && m1_reg[5:3] == 3'b111 |-> irq_n)
        else $error("interrupt active with all masks set");
    a_step_port: assert property (settled && step_pulse |-> !m0_reg[5])
        else $error("step pulse on bus type port");
    a_bus_port: assert property (settled && |drive_bus_oe |-> m0_reg[5])
        else $error("drive bus driven on step type port");
    a_step_width: assert property ($rose(step_pulse) |-> step_pulse [*4] ##1 !step_pulse)
        else $error("step pulse width wrong");
    a_steal_drop: assert property (settled && m1_reg[7:6] == 2'b10 && dma_ack |=> !dma_req)
        else $error("request held after ack in cycle steal");
endmodule // dkcp_monitor

bind dkcp_core dkcp_monitor u_mon (
    .clk(clk), .arst_n(arst_n), .host_sel(host_sel), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .irq_n(irq_n),
    .dma_req(dma_req), .dma_ack(dma_ack), .drive_bus_oe(drive_bus_oe),
    .step_pulse(step_pulse), .nrz_mode(nrz_mode), .hard_sector(hard_sector)
);

// ==== tb/dkcp_dma_model.sv ====
// System DMA controller model: acks requests until its word count runs out.
// Assumes the host loads the count before any disk or buffer command.
module dkcp_dma_model (
    input wire clk,
    input wire arst_n,
    input wire load,
    input wire [7:0] limit,
    input wire [1:0] slow,
    input wire dma_req,
    output reg dma_ack,
    output reg [7:0] dma_wdata,
    output reg [7:0] count_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [1:0] gap_reg; // Idle cycles still to wait
    // One word per ack; data toggles when not moving a word
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_ack <= 1'b0;
            dma_wdata <= 8'h00;
            count_reg <= 8'h00;
            gap_reg <= 2'h0;
        end else begin
            dma_ack <= 1'b0;
            dma_wdata <= ~dma_wdata;
            if (load) begin
                count_reg <= 8'h00;
                gap_reg <= 2'h0;
            end else if (gap_reg != 2'h0) begin
                gap_reg <= gap_reg - 2'h1;
            end else if (dma_req && !dma_ack && count_reg != limit) begin
                dma_ack <= 1'b1;
                dma_wdata <= 8'hA0 + count_reg;
                count_reg <= count_reg + 8'h01;
                gap_reg <= slow;
            end
        end
    end
endmodule // dkcp_dma_model

// ==== tb/test_dkcp_core.sv ====
// Self-checking bench for the host command block with a DMA model.
// Assumes a 10 MHz clock and the host port timing of the core.
module test_dkcp_core;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int XW = 16;
    reg clk = 0, arst_n = 0, host_sel = 0, host_wr = 0, host_rd = 0;
    reg seek_done_in = 0, drive_fault_in = 0, load = 0, saw_step = 0, saw_oe = 0;
    reg [7:0] host_wdata = 8'h00, limit = 8'h00, st, m, last_byte;
    reg [1:0] slow = 2'h0;
    wire [7:0] host_rdata, dma_wdata, dma_rdata, drive_data, cnt;
    wire irq_n, dma_req, dma_ack, ddv, step_pulse, nrz_mode, hard_sector;
    wire [4:0] bus_out, bus_oe;
    int num_errors = 0, total_checks = 0, k, nbytes = 0;
    always #50 clk = ~clk;
    dkcp_core #(.XFER_WORDS(XW)) dut (
        .clk(clk), .arst_n(arst_n), .host_sel(host_sel), .host_wdata(host_wdata),
        .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .irq_n(irq_n),
        .dma_req(dma_req), .dma_ack(dma_ack), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
        .seek_done_in(seek_done_in), .drive_fault_in(drive_fault_in), .drive_data(drive_data),
        .drive_data_valid(ddv), .drive_bus_out(bus_out), .drive_bus_oe(bus_oe),
        .drive_bus_in((bus_oe & bus_out) | (~bus_oe & 5'h1F)), .step_pulse(step_pulse),
        .nrz_mode(nrz_mode), .hard_sector(hard_sector)
    );
    dkcp_dma_model dmac (
        .clk(clk), .arst_n(arst_n), .load(load), .limit(limit), .slow(slow),
        .dma_req(dma_req), .dma_ack(dma_ack), .dma_wdata(dma_wdata), .count_reg(cnt)
    );
    // Note any drive activity of either port type
    always @(posedge clk) begin
        if (step_pulse) saw_step <= 1'b1;
        if (|bus_oe) saw_oe <= 1'b1;
        // Count drive bytes and keep the last one
        if (ddv) begin
            nbytes <= nbytes + 1;
            last_byte <= drive_data;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input s, input [7:0] d);
        @(posedge clk);
        host_sel <= s;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk);
        host_wr <= 1'b0;
    endtask
    // Read data stand from the edge that ends the strobe until the next read
    task rd(input s, output [7:0] d);
        @(posedge clk);
        host_sel <= s;
        host_rd <= 1'b1;
        @(posedge clk);
        host_rd <= 1'b0;
        #1 d = host_rdata;
    endtask
    // Recall, two parameters, command, then poll until not busy
    task run(input [7:0] code, input [7:0] p0, input [7:0] p1);
        int i;
        wr(1'b0, 8'h08);
        rd(1'b0, st);
        chk(st & 8'hC0, 8'h00);
        wr(1'b1, p0);
        wr(1'b1, p1);
        wr(1'b0, code);
        rd(1'b0, st);
        chk(st & 8'h80, 8'h80);
        for (i = 0; i < 200 && st[7] !== 1'b0; i++) rd(1'b0, st);
        if (st[7] !== 1'b0) begin
            num_errors++;
            conclude;
        end
        chk(st & 8'hC0, 8'h40);
    endtask
    // Program the DMA model before the command that uses it
    task dma_load;
        @(posedge clk);
        load <= 1'b1;
        limit <= XW;
        @(posedge clk);
        load <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(1'b0, st);
        chk(st, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        // Pointer restarts at the parameter block after recall
        wr(1'b0, 8'h08);
        wr(1'b1, 8'h5A);
        wr(1'b1, 8'hC3);
        wr(1'b0, 8'h08);
        rd(1'b1, st);
        chk(st, 8'h5A);
        rd(1'b1, st);
        chk(st, 8'hC3);
        // Each sector and coding combination, last one bus type
        for (k = 0; k < 4; k++) begin
            m = (k == 3) ? 8'h20 : (8'h40 * (3 - k));
            run(8'hE8, m, 8'h00);
            chk({6'h0, hard_sector, nrz_mode}, {6'h0, m[7:6]});
        end
        // Seek on the bus type port, done and seek flags unmasked
        saw_step = 1'b0;
        saw_oe = 1'b0;
        seek_done_in <= 1'b1;
        run(8'hC0, 8'h00, 8'h00);
        chk({6'h0, saw_oe, saw_step}, 8'h02);
        chk(st & 8'h30, 8'h30);
        chk({7'h0, irq_n}, 8'h00);
        seek_done_in <= 1'b0;
        wr(1'b0, 8'h08);
        rd(1'b0, st);
        chk(st, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        // Step port, done masked, drive fault still raises interrupt
        run(8'hE8, 8'h00, 8'h20);
        saw_step = 1'b0;
        saw_oe = 1'b0;
        drive_fault_in <= 1'b1;
        run(8'hC0, 8'h00, 8'h00);
        chk({6'h0, saw_oe, saw_step}, 8'h01);
        chk(st & 8'h28, 8'h28);
        chk({7'h0, irq_n}, 8'h00);
        drive_fault_in <= 1'b0;
        // All three masks set
        run(8'hE8, 8'h00, 8'h38);
        run(8'hC0, 8'h00, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        // DMA cycle steal into the buffer
        run(8'hE8, 8'h00, 8'h80);
        dma_load;
        run(8'h90, 8'h00, 8'h00);
        chk(cnt, XW);
        chk({7'h0, irq_n}, 8'h00);
        // DMA burst out of the buffer with a slow partner
        slow <= 2'h2;
        run(8'hE8, 8'h00, 8'hC0);
        dma_load;
        run(8'h50, 8'h00, 8'h00);
        chk(cnt, XW);
        chk(dma_rdata, 8'hAF);
        // Drive streams of a write and a read: data, check code, one pad byte each
        run(8'hE8, 8'h10, 8'h00);
        nbytes = 0;
        run(8'h87, 8'h00, 8'h00);
        chk(nbytes == 16'h0103, 8'h01);
        chk(last_byte, 8'h4E);
        run(8'hE8, 8'h89, 8'h00);
        nbytes = 0;
        run(8'h40, 8'h00, 8'h00);
        chk(nbytes == 16'h0105, 8'h01);
        chk(last_byte, 8'h00);
        // Host moves the buffer itself through the open commands
        run(8'h38, 8'h00, 8'h20);
        wr(1'b1, 8'h3C);
        wr(1'b1, 8'hC5);
        run(8'h30, 8'h00, 8'h20);
        rd(1'b1, st);
        chk(st, 8'h3C);
        rd(1'b1, st);
        chk(st, 8'hC5);
        conclude;
    end
endmodule // test_dkcp_core
